// file: hdl/ptf_pkg.sv
package ptf_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CMD = 5'h04;
  localparam logic [4:0] OFF_OPER = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_RESULT = 5'h10;
  localparam logic [4:0] OFF_EXC = 5'h14;
  localparam logic [4:0] OFF_ADDR = 5'h18;
  localparam logic [4:0] OFF_TASK = 5'h1C;
  // Command codes (CMD register bits 3:0)
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_EXC = 4'h1;
  localparam logic [3:0] CMD_JMP_TASK = 4'h2;
  localparam logic [3:0] CMD_CALL_TASK = 4'h3;
  localparam logic [3:0] CMD_INT_GATE = 4'h4;
  localparam logic [3:0] CMD_INTERRUPT_RETURN_OP = 4'h5;
  localparam logic [3:0] CMD_COPROC = 4'h6;
  localparam logic [3:0] CMD_ADJUST_REQUEST_PRIV = 4'h7;
  localparam logic [3:0] CMD_VERIFY_READABLE = 4'h8;
  localparam logic [3:0] CMD_VERIFY_WRITABLE = 4'h9;
  localparam logic [3:0] CMD_LSL = 4'hA;
  localparam logic [3:0] CMD_LAR = 4'hB;
  localparam logic [3:0] CMD_STACK_ALL = 4'hC;
  localparam logic [3:0] CMD_LOAD_MSW = 4'hD;
  localparam logic [3:0] CMD_LOAD_CS = 4'hE;
  localparam logic [3:0] CMD_NMI = 4'hF;
  // Exception vectors
  localparam logic [7:0] VEC_NONE = 8'hFF;
  localparam logic [7:0] VEC_COPROC = 8'h07;
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
  localparam logic [7:0] VEC_STACK = 8'h0C;
  localparam logic [7:0] VEC_GP = 8'h0D;
  // Flag and status word bit positions
  localparam int NT_BIT = 14;
  localparam int PE_BIT = 0;
  localparam int MP_BIT = 1;
  localparam int TS_BIT = 3;
  // Descriptor types for task state segments
  localparam logic [3:0] TYPE_TSS_IDLE = 4'h1;
  localparam logic [3:0] TYPE_TSS_BUSY = 4'h3;
  // Reset values and minimum task state segment limit
  localparam logic [15:0] RESET_CS = 16'hF000;
  localparam logic [15:0] RESET_IP = 16'hFFF0;
  localparam logic [15:0] TSS_MIN_LIMIT = 16'h002B;
  // Operand field positions in the OPER register
  localparam int OP_SEL_LO = 0;
  localparam int OP_AUX_LO = 16;
  // Command register flag bits
  localparam int CB_PRESENT = 4;
  localparam int CB_IS_SS = 5;
  localparam int CB_READABLE = 6;
  localparam int CB_WRITABLE = 7;
  localparam int CB_PRIV_OK = 8;
  localparam int CB_HAS_CODE = 9;
  localparam int CB_OVERRUN = 10;
  localparam int CB_PREFIX_LO = 12;
  localparam int CB_BUSY = 11;
  localparam int CB_DESC_LO = 16;
  localparam int CB_LIMIT_OK = 24;
  localparam int CB_VEC_LO = 24;
endpackage

// file: hdl/ptf_ptr_test.sv
`timescale 1ns/1ps
module ptf_ptr_test (
  // Operation
  input wire logic [3:0] op,
  input wire logic [15:0] sel,
  input wire logic [15:0] aux,
  input wire logic readable,
  input wire logic writable,
  input wire logic priv_ok,
  input wire logic type_ok,
  input wire logic [7:0] access_rights,
  input wire logic [15:0] limit,
  // Answer
  output logic [15:0] result,
  output logic zero_flag
);
  function automatic logic [1:0] max_priv(input logic [1:0] a,
                                          input logic [1:0] b);
    max_priv = (a > b) ? a : b;
  endfunction

  always_comb begin
    result = sel;
    zero_flag = 1'b0;
    unique case (op)
      ptf_pkg::CMD_ADJUST_REQUEST_PRIV: begin
        result = {sel[15:2], max_priv(sel[1:0], aux[1:0])};
        zero_flag = (aux[1:0] > sel[1:0]);
      end
      ptf_pkg::CMD_VERIFY_READABLE: zero_flag = readable;
      ptf_pkg::CMD_VERIFY_WRITABLE: zero_flag = writable;
      ptf_pkg::CMD_LSL: begin
        zero_flag = priv_ok && type_ok;
        result = zero_flag ? limit : aux;
      end
      ptf_pkg::CMD_LAR: begin
        zero_flag = priv_ok;
        result = zero_flag ? {access_rights, 8'h00} : aux;
      end
      default: begin
        result = sel;
        zero_flag = 1'b0;
      end
    endcase
  end
endmodule

// file: hdl/ptf_addr_force.sv
`timescale 1ns/1ps
module ptf_addr_force (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic cs_reload,
  input wire logic code_ref,
  input wire logic real_mode,
  // Answer
  output logic [3:0] upper_addr
);
  typedef struct packed {
    logic cs_changed;
    logic [3:0] upper;
  } ptf_af_t;
  ptf_af_t st;
  ptf_af_t next_st;

  always_comb begin
    next_st = st;
    if (cs_reload) begin
      next_st.cs_changed = 1'b1;
    end
    if (real_mode && code_ref && !next_st.cs_changed) begin
      next_st.upper = 4'hF;
    end else begin
      next_st.upper = 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign upper_addr = st.upper;

  a_force_high: assert property (@(posedge ref_clk) disable iff (rst)
    (real_mode && code_ref && !st.cs_changed && !cs_reload)
    |=> upper_addr == 4'hF) else $error("upper bits not forced high");
  a_force_low: assert property (@(posedge ref_clk) disable iff (rst)
    (st.cs_changed || !code_ref) |=> upper_addr == 4'h0)
    else $error("upper bits not low");
endmodule

// file: hdl/ptf_unit.sv
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module ptf_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Code fetch reference for address forcing
  input wire logic code_ref,
  // Bus status outputs
  output logic [3:0] upper_addr,
  output logic halt_cycle,
  output logic shutdown_address_bit
);
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} ptf_state_t;

  typedef struct packed {
    ptf_state_t state;
    logic [31:0] cmd;
    logic [31:0] oper;
    logic [15:0] flags;
    logic [15:0] machine_status_word;
    logic [15:0] task_register;
    logic [15:0] back_link;
    logic [3:0] new_type;
    logic [3:0] old_type;
    logic [15:0] result;
    logic [7:0] vector;
    logic [15:0] error_code;
    logic [15:0] stack_pointer;
    logic [15:0] cs;
    logic [15:0] instruction_pointer;
    logic zero_flag;
    logic in_exception;
    logic in_double;
    logic shutdown;
    logic restartable;
    logic cs_reload;
    logic [31:0] rdata;
    logic ack;
  } ptf_st_t;

  ptf_st_t st;
  ptf_st_t next_st;

  logic [3:0] op;
  logic [15:0] pt_result;
  logic pt_zero;
  logic is_ss;
  logic has_code;
  logic [15:0] sel;
  logic [15:0] aux;
  logic [31:0] ctrl_wr;
  logic [31:0] sp_wr;

  assign op = st.cmd[3:0];
  assign sel = st.oper[ptf_pkg::OP_SEL_LO +: 16];
  assign aux = st.oper[ptf_pkg::OP_AUX_LO +: 16];
  assign is_ss = st.cmd[ptf_pkg::CB_IS_SS];
  assign has_code = st.cmd[ptf_pkg::CB_HAS_CODE];

  ptf_ptr_test u_ptr (
    .op(op),
    .sel(sel),
    .aux(aux),
    .readable(st.cmd[ptf_pkg::CB_READABLE]),
    .writable(st.cmd[ptf_pkg::CB_WRITABLE]),
    .priv_ok(st.cmd[ptf_pkg::CB_PRIV_OK]),
    .type_ok(st.cmd[ptf_pkg::CB_LIMIT_OK]),
    .access_rights(st.cmd[ptf_pkg::CB_DESC_LO +: 8]),
    .limit(aux),
    .result(pt_result),
    .zero_flag(pt_zero)
  );

  ptf_addr_force u_force (
    .ref_clk(ref_clk),
    .rst(rst),
    .cs_reload(st.cs_reload),
    .code_ref(code_ref),
    .real_mode(!st.machine_status_word[ptf_pkg::PE_BIT]),
    .upper_addr(upper_addr)
  );

  // Merge a 32-bit write under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  // Byte-lane merged write images of the control and address words
  assign ctrl_wr = merge({st.flags, st.machine_status_word}, avs_writedata,
    avs_byteenable);
  assign sp_wr = merge({st.stack_pointer, 16'h0000}, avs_writedata,
    avs_byteenable);

  // Raise an exception, escalating to double fault and shutdown
  function automatic ptf_st_t raise(input ptf_st_t s,
                                    input logic [7:0] vec,
                                    input logic [15:0] code,
                                    input logic restart);
    ptf_st_t r;
    r = s;
    if (s.in_double) begin
      r.shutdown = 1'b1;
      r.vector = ptf_pkg::VEC_NONE;
    end else if (s.in_exception) begin
      r.in_double = 1'b1;
      r.vector = ptf_pkg::VEC_DOUBLE;
      r.error_code = 16'h0000;
      r.restartable = 1'b0;
    end else begin
      r.in_exception = 1'b1;
      r.vector = vec;
      r.error_code = code;
      r.restartable = restart;
    end
    r.flags[ptf_pkg::NT_BIT] = 1'b0;
    raise = r;
  endfunction

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.cs_reload = 1'b0;
    // Register access, answered one cycle after the request is seen
    if ((avs_read || avs_write) && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.rdata = 32'h00000000;
      if (avs_read) begin
        unique case (avs_address)
          ptf_pkg::OFF_CTRL: next_st.rdata = {st.flags, st.machine_status_word};
          ptf_pkg::OFF_CMD: next_st.rdata = st.cmd;
          ptf_pkg::OFF_OPER: next_st.rdata = st.oper;
          ptf_pkg::OFF_STATUS: next_st.rdata = {26'h0000000, st.restartable,
            st.zero_flag, st.shutdown, st.in_double, st.in_exception,
            st.state != ST_IDLE};
          ptf_pkg::OFF_RESULT: next_st.rdata = {st.back_link, st.result};
          ptf_pkg::OFF_EXC: next_st.rdata = {8'h00, st.vector,
                                             st.error_code};
          ptf_pkg::OFF_ADDR: next_st.rdata = {st.cs, st.instruction_pointer};
          ptf_pkg::OFF_TASK: next_st.rdata = {st.new_type, st.old_type,
            8'h00, st.task_register};
          default: next_st.rdata = 32'h00000000;
        endcase
      end else begin
        unique case (avs_address)
          ptf_pkg::OFF_CTRL: begin
            next_st.flags = ctrl_wr[31:16];
            next_st.machine_status_word = ctrl_wr[15:0];
          end
          ptf_pkg::OFF_CMD: begin
            next_st.cmd = merge(st.cmd, avs_writedata, avs_byteenable);
            next_st.state = ST_EXEC;
          end
          ptf_pkg::OFF_OPER: next_st.oper = merge(st.oper, avs_writedata,
                                                  avs_byteenable);
          ptf_pkg::OFF_ADDR: begin
            next_st.stack_pointer = sp_wr[31:16];
          end
          default: begin
          end
        endcase
      end
    end
    // Command execution; shutdown only lets NMI through
    if (st.state == ST_EXEC) begin
      next_st.state = ST_DONE;
      next_st.zero_flag = 1'b0;
      if (st.shutdown) begin
        if (op == ptf_pkg::CMD_NMI) begin
          next_st.shutdown = 1'b0;
          next_st.in_exception = 1'b0;
          next_st.in_double = 1'b0;
        end
      end else begin
        unique case (op)
          ptf_pkg::CMD_EXC: begin
            // Raise first so the saved return address is not lost
            if (!st.cmd[ptf_pkg::CB_PRESENT]) begin
              next_st = raise(next_st, is_ss ? ptf_pkg::VEC_STACK
                : ptf_pkg::VEC_NOT_PRESENT, sel, 1'b1);
            end else begin
              next_st = raise(next_st, st.cmd[ptf_pkg::CB_VEC_LO +: 8],
                              has_code ? sel : 16'h0000, 1'b1);
            end
            if (st.cmd[ptf_pkg::CB_OVERRUN]) begin
              next_st.instruction_pointer = aux;
            end else begin
              next_st.instruction_pointer = aux -
                16'(st.cmd[ptf_pkg::CB_PREFIX_LO +: 4]);
            end
          end
          ptf_pkg::CMD_JMP_TASK, ptf_pkg::CMD_CALL_TASK,
          ptf_pkg::CMD_INT_GATE: begin
            if (st.cmd[ptf_pkg::CB_BUSY]) begin
              next_st = raise(next_st, ptf_pkg::VEC_GP, sel, 1'b0);
              next_st.state = ST_DONE;
            end else begin
              next_st.back_link = st.task_register;
              next_st.task_register = sel;
              next_st.new_type = ptf_pkg::TYPE_TSS_BUSY;
              next_st.old_type = (op == ptf_pkg::CMD_JMP_TASK)
                ? ptf_pkg::TYPE_TSS_IDLE : ptf_pkg::TYPE_TSS_BUSY;
              next_st.flags[ptf_pkg::NT_BIT] =
                (op != ptf_pkg::CMD_JMP_TASK);
              next_st.machine_status_word[ptf_pkg::TS_BIT] = 1'b1;
              next_st.in_exception = 1'b0;
            end
          end
          ptf_pkg::CMD_INTERRUPT_RETURN_OP: begin
            if (st.flags[ptf_pkg::NT_BIT]) begin
              next_st.task_register = st.back_link;
              next_st.back_link = st.task_register;
              next_st.old_type = ptf_pkg::TYPE_TSS_IDLE;
              next_st.machine_status_word[ptf_pkg::TS_BIT] = 1'b1;
            end
            next_st.flags = aux;
            next_st.in_exception = 1'b0;
          end
          ptf_pkg::CMD_COPROC: begin
            if (st.machine_status_word[ptf_pkg::TS_BIT] &&
                st.machine_status_word[ptf_pkg::MP_BIT]) begin
              next_st = raise(next_st, ptf_pkg::VEC_COPROC, 16'h0000,
                              1'b1);
              next_st.state = ST_DONE;
            end
          end
          ptf_pkg::CMD_ADJUST_REQUEST_PRIV, ptf_pkg::CMD_VERIFY_READABLE, ptf_pkg::CMD_VERIFY_WRITABLE,
          ptf_pkg::CMD_LSL, ptf_pkg::CMD_LAR: begin
            next_st.result = pt_result;
            next_st.zero_flag = pt_zero;
          end
          ptf_pkg::CMD_STACK_ALL: begin
            if (st.cmd[ptf_pkg::CB_OVERRUN]) begin
              next_st = raise(next_st, ptf_pkg::VEC_STACK, 16'h0000,
                              1'b0);
              next_st.state = ST_DONE;
            end
          end
          ptf_pkg::CMD_LOAD_MSW: begin
            // Protection enable cannot be cleared by this command, only by reset or a write to OFF_CTRL
            next_st.machine_status_word = aux |
              {15'h0000, st.machine_status_word[ptf_pkg::PE_BIT]};
          end
          ptf_pkg::CMD_LOAD_CS: begin
            next_st.cs = sel;
            next_st.cs_reload = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end else if (st.state == ST_DONE) begin
      next_st.state = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.cs <= ptf_pkg::RESET_CS;
      st.instruction_pointer <= ptf_pkg::RESET_IP;
      st.vector <= ptf_pkg::VEC_NONE;
      st.state <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign halt_cycle = st.shutdown;
  assign shutdown_address_bit = 1'b0;

  sequence s_switch_cmd;
    st.state == ST_EXEC && !st.shutdown && !st.cmd[ptf_pkg::CB_BUSY] &&
    (op == ptf_pkg::CMD_CALL_TASK || op == ptf_pkg::CMD_INT_GATE);
  endsequence

  a_switch_sets_ts: assert property (@(posedge ref_clk) disable iff (rst)
    s_switch_cmd |=> st.machine_status_word[ptf_pkg::TS_BIT] &&
    st.flags[ptf_pkg::NT_BIT]) else $error("switch flags wrong");
  a_back_link: assert property (@(posedge ref_clk) disable iff (rst)
    s_switch_cmd |=> st.back_link == $past(st.task_register) &&
    st.task_register == $past(sel)) else $error("back link wrong");
  a_busy_gp: assert property (@(posedge ref_clk) disable iff (rst)
    (st.state == ST_EXEC && !st.shutdown && !st.in_exception &&
     (op == ptf_pkg::CMD_JMP_TASK || op == ptf_pkg::CMD_CALL_TASK ||
      op == ptf_pkg::CMD_INT_GATE) && st.cmd[ptf_pkg::CB_BUSY])
    |=> st.vector == ptf_pkg::VEC_GP) else $error("busy not 13");
  a_coproc_7: assert property (@(posedge ref_clk) disable iff (rst)
    (st.state == ST_EXEC && !st.shutdown && !st.in_exception &&
     op == ptf_pkg::CMD_COPROC && st.machine_status_word[ptf_pkg::TS_BIT] &&
     st.machine_status_word[ptf_pkg::MP_BIT])
    |=> st.vector == ptf_pkg::VEC_COPROC) else $error("no vector 7");
  a_double_fault: assert property (@(posedge ref_clk) disable iff (rst)
    (st.state == ST_EXEC && !st.shutdown && st.in_exception &&
     !st.in_double && op == ptf_pkg::CMD_EXC)
    |=> st.vector == ptf_pkg::VEC_DOUBLE) else $error("no double");
  a_shutdown_halt: assert property (@(posedge ref_clk) disable iff (rst)
    st.shutdown |-> halt_cycle && !shutdown_address_bit)
    else $error("shutdown not shown");
  a_not_present: assert property (@(posedge ref_clk) disable iff (rst)
    (st.state == ST_EXEC && !st.shutdown && !st.in_exception &&
     op == ptf_pkg::CMD_EXC && !st.cmd[ptf_pkg::CB_PRESENT] && is_ss)
    |=> st.vector == ptf_pkg::VEC_STACK && st.restartable)
    else $error("stack not present wrong");
  a_wait_answer: assert property (@(posedge ref_clk) disable iff (rst)
    (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("bus answer late");
  a_zero_verify: assert property (@(posedge ref_clk) disable iff (rst)
    (st.state == ST_EXEC && !st.shutdown && op == ptf_pkg::CMD_VERIFY_READABLE)
    |=> st.zero_flag == $past(st.cmd[ptf_pkg::CB_READABLE]) &&
    !st.in_exception == !$past(st.in_exception))
    else $error("verify wrong");
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic code_ref = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] upper_addr;
  logic halt_cycle;
  logic shutdown_address_bit;
  logic [31:0] q;
  int err_total = 0;
  int samples_checked = 0;

  always #5 ref_clk = ~ref_clk;

  ptf_unit DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .code_ref(code_ref),
    .upper_addr(upper_addr),
    .halt_cycle(halt_cycle),
    .shutdown_address_bit(shutdown_address_bit)
  );

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // Request held until waitrequest is seen low, then released
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Values read right after the edge are those sampled at that edge
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) begin
        chk("waitrequest", 32'h1, 32'h0);
        stop_test();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic op(logic [3:0] c, logic [27:0] hi, logic [31:0] o);
    bus(1'b1, ptf_pkg::OFF_OPER, o);
    bus(1'b1, ptf_pkg::OFF_CMD, {hi, c});
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic vec(logic [7:0] e);
    rd(ptf_pkg::OFF_EXC);
    chk("vector", {24'h0, q[23:16]}, {24'h0, e});
  endtask

  task automatic jmp(logic [15:0] s);
    op(ptf_pkg::CMD_JMP_TASK, 28'h0000001, {16'h0, s});
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
  endtask

  task automatic t_init();
    rd(ptf_pkg::OFF_ADDR);
    chk("cs_ip", q, {ptf_pkg::RESET_CS, ptf_pkg::RESET_IP});
    code_ref <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("upper_code", {28'h0, upper_addr}, 32'hF);
    @(posedge ref_clk);
    code_ref <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("upper_data", {28'h0, upper_addr}, 32'h0);
    op(ptf_pkg::CMD_LOAD_CS, 28'h0, 32'h0);
    code_ref <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("upper_reload", {28'h0, upper_addr}, 32'h0);
  endtask

  // Bit 16 of r asks for a result comparison
  task automatic ptr(logic [3:0] c, logic [27:0] hi, logic [31:0] o,
                     logic z, logic [16:0] r);
    op(c, hi, o);
    rd(ptf_pkg::OFF_STATUS);
    chk("zero_flag", {31'h0, q[4]}, {31'h0, z});
    if (r[16]) begin
      rd(ptf_pkg::OFF_RESULT);
      chk("result", {16'h0, q[15:0]}, {16'h0, r[15:0]});
    end
  endtask

  task automatic t_ptr();
    ptr(4'h7, 28'h0, 32'h0003_0011, 1'b1, 17'h10013);
    ptr(4'h7, 28'h0, 32'h0001_0013, 1'b0, 17'h10013);
    ptr(4'h8, 28'h4, 32'h0010, 1'b1, 17'h0);
    ptr(4'h8, 28'h8, 32'h0010, 1'b0, 17'h0);
    ptr(4'h9, 28'h8, 32'h0010, 1'b1, 17'h0);
    ptr(4'h9, 28'h4, 32'h0010, 1'b0, 17'h0);
    ptr(4'hA, 28'h0100010, 32'h1234_0008, 1'b1, 17'h11234);
    ptr(4'hA, 28'h0100000, 32'h1234_0008, 1'b0, 17'h0);
    ptr(4'hB, 28'h0082010, 32'h0008, 1'b1, 17'h18200);
    ptr(4'hB, 28'h0082000, 32'h0008, 1'b0, 17'h0);
  endtask

  task automatic t_task();
    op(ptf_pkg::CMD_CALL_TASK, 28'h0000001, 32'h0040);
    op(ptf_pkg::CMD_INT_GATE, 28'h0000001, 32'h0050);
    rd(ptf_pkg::OFF_TASK);
    chk("call_types", {8'h0, q[31:24], q[15:0]},
        32'h0033_0050);
    rd(ptf_pkg::OFF_RESULT);
    chk("back_link", {16'h0, q[31:16]}, 32'h0040);
    rd(ptf_pkg::OFF_CTRL);
    chk("nt_ts", {30'h0, q[30], q[3]}, 32'h3);
    op(ptf_pkg::CMD_INTERRUPT_RETURN_OP, 28'h0, 32'h0);
    rd(ptf_pkg::OFF_TASK);
    chk("interrupt_return_op_link", {16'h0, q[15:0]}, 32'h0040);
    bus(1'b1, ptf_pkg::OFF_CTRL, 32'h0);
    op(ptf_pkg::CMD_INTERRUPT_RETURN_OP, 28'h0, 32'h0200_0000);
    rd(ptf_pkg::OFF_CTRL);
    chk("interrupt_return_op_pop", {16'h0, q[31:16]}, 32'h0200);
    rd(ptf_pkg::OFF_TASK);
    chk("interrupt_return_op_stay", {16'h0, q[15:0]}, 32'h0040);
    jmp(16'h0048);
    rd(ptf_pkg::OFF_TASK);
    chk("jmp_types", {8'h0, q[31:24], q[15:0]},
        32'h0031_0048);
  endtask

  task automatic t_exc();
    op(ptf_pkg::CMD_EXC, 28'h0000220, 32'h0105_0028);
    rd(ptf_pkg::OFF_EXC);
    chk("np_code", {8'h0, q[23:0]}, 32'h000B_0028);
    rd(ptf_pkg::OFF_ADDR);
    chk("ret_ip", {16'h0, q[15:0]}, 32'h0103);
    rd(ptf_pkg::OFF_STATUS);
    chk("restart", {31'h0, q[5]}, 32'h1);
    jmp(16'h0040);
    op(ptf_pkg::CMD_EXC, 28'h0000002, 32'h0);
    rd(ptf_pkg::OFF_EXC);
    chk("ss_code", {8'h0, q[23:0]}, 32'h000C_0000);
    jmp(16'h0048);
    bus(1'b1, ptf_pkg::OFF_ADDR, 32'hFFFE_0000);
    op(ptf_pkg::CMD_STACK_ALL, 28'h0000040, 32'h0);
    vec(ptf_pkg::VEC_STACK);
    rd(ptf_pkg::OFF_STATUS);
    chk("wrap_restart", {31'h0, q[5]}, 32'h0);
    jmp(16'h0040);
    op(ptf_pkg::CMD_CALL_TASK, 28'h0000081, 32'h0048);
    vec(ptf_pkg::VEC_GP);
    op(ptf_pkg::CMD_LOAD_MSW, 28'h0, 32'h0003_0000);
    rd(ptf_pkg::OFF_CTRL);
    chk("msw_load", {30'h0, q[1:0]}, 32'h3);
    jmp(16'h0048);
    op(ptf_pkg::CMD_COPROC, 28'h0, 32'h0);
    vec(ptf_pkg::VEC_COPROC);
    op(ptf_pkg::CMD_EXC, 28'h0D00001, 32'h0);
    vec(ptf_pkg::VEC_DOUBLE);
    op(ptf_pkg::CMD_EXC, 28'h0D00001, 32'h0);
    rd(ptf_pkg::OFF_STATUS);
    chk("shutdown", {29'h0, q[3], halt_cycle, shutdown_address_bit},
        32'h6);
    op(ptf_pkg::CMD_NMI, 28'h0, 32'h0);
    rd(ptf_pkg::OFF_CTRL);
    chk("nmi_exit", {30'h0, halt_cycle, q[0]}, 32'h1);
    do_reset();
    rd(ptf_pkg::OFF_CTRL);
    chk("reset_real", {31'h0, q[0]}, 32'h0);
    chk("upper_reset", {28'h0, upper_addr}, 32'hF);
  endtask

  initial begin
    do_reset();
    t_init();
    t_ptr();
    t_task();
    t_exc();
    stop_test();
  end
endmodule
